/* core/hpr_error_report.sv */
// Command error register with sector search index counting
`timescale 1ns/1ns
module hpr_error_report
  import hpr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cmdStart,
  input wire logic retryDisable,
  input wire logic idSearch,
  input wire logic indexPulse,
  input wire logic scanSeekDone,
  input wire hpr_err_ev_t ev,
  output logic scanSeekReq,
  output logic [7:0] errReg
);
  typedef enum logic [1:0] {
    SRCH_IDLE = 2'b00,
    SRCH_FIRST = 2'b01,
    SRCH_SCAN = 2'b10,
    SRCH_SECOND = 2'b11
  } hpr_srch_t;
  typedef struct packed {
    hpr_srch_t srch;
    logic [3:0] idx;
    logic seekReq;
    logic [7:0] err;
  } hpr_err_st_t;
  hpr_err_st_t s_reg;
  hpr_err_st_t s_next;
  logic [3:0] limit;

  // Search walk and sticky error bits
  always_comb begin
    s_next = s_reg;
    s_next.seekReq = 1'b0;
    limit = retryDisable ? HPR_IDX_NORETRY : HPR_IDX_RETRY;
    if (cmdStart) begin
      s_next.err = '0;
      s_next.srch = SRCH_IDLE;
      s_next.idx = '0;
    end
    case (s_reg.srch)
      SRCH_IDLE: begin
        if (idSearch) begin
          s_next.srch = SRCH_FIRST;
          s_next.idx = '0;
        end
      end
      SRCH_FIRST, SRCH_SECOND: begin
        if (!idSearch) begin
          // ID matched or search dropped
          s_next.srch = SRCH_IDLE;
        end else if (indexPulse) begin
          s_next.idx = s_reg.idx + 4'h1;
          if (s_reg.idx + 4'h1 == limit) begin
            s_next.idx = '0;
            if (s_reg.srch == SRCH_FIRST && !retryDisable) begin
              s_next.srch = SRCH_SCAN;
              s_next.seekReq = 1'b1;
            end else begin
              s_next.err[4] = 1'b1;
              s_next.srch = SRCH_IDLE;
            end
          end
        end
      end
      SRCH_SCAN: begin
        // Scan and seek run outside, index pulses not counted
        if (!idSearch) begin
          s_next.srch = SRCH_IDLE;
        end else if (scanSeekDone) begin
          s_next.srch = SRCH_SECOND;
        end
      end
      default: s_next.srch = SRCH_IDLE;
    endcase
    if (ev.badBlock) s_next.err[7] = 1'b1;
    if (ev.eccError) s_next.err[6] = 1'b1;
    if (ev.homeTrack) s_next.err[1] = 1'b1;
    if (ev.notReady || ev.writeFault || ev.illegalCode) s_next.err[2] = 1'b1;
    if (ev.markCheck && ev.readSector && ev.markBytes != HPR_DATA_MARK) s_next.err[0] = 1'b1;
    s_next.err[5] = 1'b0;
    s_next.err[3] = 1'b0;
  end

  // State register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign errReg = s_reg.err;
  assign scanSeekReq = s_reg.seekReq;
endmodule

/* core/hpr_host_port_register_decode.sv */
// Host register port: legacy byte ports and task-file decode
//
// Overview of operation
// - Mode bit selects legacy or task-file decode
// - Legacy offset 0 moves bytes via buffer
// - Legacy status byte readable, mixed bit owners
// - Status bit 5 mirrors interrupt; clears on reset
// - Status bit 4 mirrors DMA request line
// - Busy bit set by reset, cleared by micro
// - Command/data and direction bits from microcontroller
// - Request bit marks byte ready; host waits
// - Legacy offset 1 write resets or interrupts micro
// - Legacy offset 2 read returns drive config
// - Legacy offset 2 write interrupts microcontroller
// - Mask bit 1 enables host interrupt
// - Mask bit 0 enables DMA, cleared by reset
// - Task-file offsets 1-7 address register copy
// - Busy: reads give status, writes ignored
// - Task-file offset 0 flags wide cycle
// - Error register bits, 5 and 3 zero
// - Sector id missing after index pulse counts
// - Abort on not-ready, fault, illegal code
// - Read sector checks data mark bytes
`timescale 1ns/1ns
module hpr_host_port_register_decode
  import hpr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  // Host bus, chip select decoded outside
  input wire hpr_host_bus_t host,
  output logic [15:0] hostDataOut,
  output logic hostDataOe,
  output logic wideCycle,
  output logic hostIntLine,
  output logic hostIntOe,
  output logic dmaRequestLine,
  output logic resetOut,
  // Buffer manager side
  input wire logic [15:0] bufRdData,
  input wire logic bufReady,
  input wire logic dmaRequestFlag,
  output logic bufRdStrobe,
  output logic bufWrStrobe,
  output logic [15:0] bufWrData,
  // Local microcontroller side
  input wire hpr_mc_bus_t mc,
  output logic [7:0] mcDataOut,
  output logic localCpuInt,
  output logic [7:0] commandCode,
  // Drive and formatter side
  input wire logic indexIn,
  input wire logic writeGateIn,
  input wire logic idSearch,
  input wire logic indexPulse,
  input wire logic scanSeekDone,
  input wire hpr_err_ev_t errEv,
  output logic scanSeekReq
);
  // Whole state of the port
  typedef struct packed {
    // Registers the micro writes, plus host-written control and command
    logic [7:0] ifCtl;
    logic [7:0] lstat;
    logic [7:0] conf;
    logic [7:0] hstat;
    logic [7:0] fixedDisk;
    logic [7:0] cmd;
    logic [6:0][7:0] taskFile;
    // Host masks, busy flags, reset level and micro interrupt
    logic hostIntEnable;
    logic hostDmaEnable;
    logic commandBusy;
    logic legacyBusy;
    logic rstLevel;
    logic local_cpu_interrupt;
    // Registered read paths
    logic [15:0] rdData;
    logic rdOe;
    logic [7:0] mcRd;
  } hpr_st_t;
  hpr_st_t s_reg;
  hpr_st_t s_next;

  // Decode of the current host cycle
  logic taskMode;
  logic hostRead;
  logic hostWrite;
  // Reset and interrupt controls
  logic devReset;
  logic intSet;
  logic intClear;
  logic intEnable;
  logic intPending;
  // Command start and error image
  logic startCmd;
  logic [7:0] errReg;
  // Status images and host read byte
  logic [7:0] hostStatus;
  logic [7:0] legacyStatus;
  logic [7:0] digitalIn;
  logic [7:0] rdByte;

  // Index of a task-file copy register, offsets 1..7 map to 0..6
  function automatic logic [2:0] tf_index(input logic [2:0] off);
    tf_index = off - 3'h1;
  endfunction

  assign taskMode = s_reg.ifCtl[HPR_IF_FLAVOUR];
  // Strobes count only while selected
  assign hostRead = host.sel && host.rd;
  assign hostWrite = host.sel && host.wr;

  // Host status image: micro bits, busy, data request, index
  always_comb begin
    hostStatus = s_reg.hstat & HPR_HSTAT_MC;
    hostStatus[7] = s_reg.commandBusy;
    hostStatus[3] = dmaRequestFlag;
    hostStatus[1] = indexIn;
  end

  // Legacy status: micro owns 7,6,2,1; logic owns 5,4,3,0
  always_comb begin
    legacyStatus = s_reg.lstat & HPR_LSTAT_MC;
    legacyStatus[5] = intPending;
    legacyStatus[4] = dmaRequestLine;
    legacyStatus[3] = s_reg.legacyBusy;
    legacyStatus[0] = bufReady;
  end

  // Write gate, head select 3 or reduced current, drive/head bits
  always_comb begin
    digitalIn = {1'b0, writeGateIn, 1'b0, s_reg.taskFile[5][4:0]};
    digitalIn[5] = s_reg.fixedDisk[HPR_FD_HS3] ? s_reg.taskFile[5][3] : s_reg.hstat[5];
  end

  // Host read byte mux for both decode sets
  always_comb begin
    rdByte = 8'h00;
    if (!taskMode) begin
      // Legacy decode ignores high select and address bit 2
      case (host.addr[1:0])
        HPR_OFF_STAT[1:0]: rdByte = legacyStatus;
        HPR_OFF_CONF[1:0]: rdByte = s_reg.conf;
        default: rdByte = 8'h00; // Mask port reads nothing
      endcase
    end else if (host.high) begin
      case (host.addr)
        HPR_OFF_ALT: rdByte = hostStatus;
        HPR_OFF_DIN: rdByte = digitalIn;
        default: rdByte = 8'h00;
      endcase
    end else if (s_reg.commandBusy) begin
      // Busy hides the whole copy behind status
      rdByte = hostStatus;
    end else begin
      case (host.addr)
        HPR_OFF_DATA: rdByte = 8'h00; // Data comes from the buffer path
        HPR_OFF_ERR: rdByte = errReg;
        HPR_OFF_CMD: rdByte = hostStatus;
        default: rdByte = s_reg.taskFile[tf_index(host.addr)];
      endcase
    end
  end

  // Buffer strobes: data port of either set, not the high page
  assign bufRdStrobe = hostRead && host.addr == HPR_OFF_DATA && !(taskMode && host.high);
  assign bufWrStrobe = hostWrite && host.addr == HPR_OFF_DATA && !(taskMode && host.high);
  assign bufWrData = taskMode ? host.data : {8'h00, host.data[7:0]};
  // Wide cycle only for programmed-I/O data port
  assign wideCycle = host.sel && taskMode && s_reg.ifCtl[HPR_IF_PIO] && !host.high
    && host.addr == HPR_OFF_DATA;

  // Command register write starts a command unless busy
  assign startCmd = taskMode && hostWrite && !host.high && !s_reg.commandBusy && host.addr == HPR_OFF_CMD;

  // Device reset from either decode set
  assign devReset = hostWrite && ((!taskMode && host.addr[1:0] == HPR_OFF_STAT[1:0])
    || (taskMode && host.high && host.addr == HPR_OFF_ALT && host.data[HPR_FD_RST]));

  // Interrupt raise from micro; clears by reset, disable, status read, command
  assign intSet = mc.wr && mc.addr == HPR_MC_STROBE && mc.data[HPR_SB_IRQ];
  always_comb begin
    intClear = devReset;
    if (!taskMode) begin
      intClear = intClear || !s_reg.hostIntEnable;
    end else begin
      intClear = intClear || startCmd || (hostRead && !host.high && host.addr == HPR_OFF_CMD);
    end
  end
  // Task-file enable is active low in the control register
  assign intEnable = taskMode ? !s_reg.fixedDisk[HPR_FD_NIEN] : s_reg.hostIntEnable;

  // Next-state logic
  always_comb begin
    s_next = s_reg;
    s_next.local_cpu_interrupt = 1'b0;
    s_next.rdOe = hostRead;
    // Buffer word (low byte in legacy) for data port, register byte elsewhere
    if (bufRdStrobe) begin
      s_next.rdData = taskMode ? bufRdData : {8'h00, bufRdData[7:0]};
    end else if (hostRead) begin
      s_next.rdData = {8'h00, rdByte};
    end
    // Host writes
    if (hostWrite && !taskMode) begin
      case (host.addr[1:0])
        HPR_OFF_STAT[1:0]: begin
          // Any data: reset if allowed, else tell the micro
          if (s_reg.ifCtl[HPR_IF_NORST]) begin
            s_next.local_cpu_interrupt = 1'b1;
          end else begin
            s_next.rstLevel = 1'b1;
          end
        end
        HPR_OFF_CONF[1:0]: s_next.local_cpu_interrupt = 1'b1;
        HPR_OFF_MASK[1:0]: begin
          // Pending interrupt clears one edge after enable drops
          s_next.hostIntEnable = host.data[HPR_MASK_IRQ];
          s_next.hostDmaEnable = host.data[HPR_MASK_DMA];
        end
        default: ;
      endcase
    end else if (hostWrite && host.high) begin
      // Control register; the input register ignores writes
      if (host.addr == HPR_OFF_ALT) begin
        s_next.fixedDisk = host.data[7:0];
        // Reset disabled: a rising bit wakes the micro; reset output is not raised
        if (host.data[HPR_FD_RST] && !s_reg.fixedDisk[HPR_FD_RST] && s_reg.ifCtl[HPR_IF_NORST]) begin
          s_next.local_cpu_interrupt = 1'b1;
        end
        // Reset output follows the bit when allowed
        s_next.rstLevel = host.data[HPR_FD_RST] && !s_reg.ifCtl[HPR_IF_NORST];
      end
    end else if (hostWrite && !s_reg.commandBusy && host.addr != HPR_OFF_DATA) begin
      // Task-file copy writes only while idle
      s_next.taskFile[tf_index(host.addr)] = host.data[7:0];
      // Command: latch code, mark busy, wake the micro
      if (host.addr == HPR_OFF_CMD) begin
        s_next.cmd = host.data[7:0];
        s_next.commandBusy = 1'b1;
        s_next.local_cpu_interrupt = 1'b1;
      end
    end
    // Host-driven reset: clear masks, mark busy
    if (devReset) begin
      s_next.hostIntEnable = 1'b0;
      s_next.hostDmaEnable = 1'b0;
      s_next.legacyBusy = 1'b1;
      s_next.commandBusy = 1'b1;
    end
    // Microcontroller writes
    if (mc.wr) begin
      case (mc.addr)
        HPR_MC_IFCTL: s_next.ifCtl = mc.data;
        HPR_MC_LSTAT: s_next.lstat = mc.data;
        HPR_MC_CONF: s_next.conf = mc.data;
        HPR_MC_HSTAT: s_next.hstat = mc.data;
        HPR_MC_STROBE: begin
          // Micro ends commands; reset wins over an end in the same cycle
          if (mc.data[HPR_SB_UNBUSY] && !devReset) begin
            s_next.commandBusy = 1'b0;
            s_next.legacyBusy = 1'b0;
          end
          // Legacy reset drops only while the control bit is clear
          if (mc.data[HPR_SB_RSTOFF] && !s_reg.fixedDisk[HPR_FD_RST]) begin
            s_next.rstLevel = 1'b0;
          end
        end
        default: begin
          // Micro loads the task-file copy, offsets 9..E
          if (mc.addr > HPR_MC_TF && mc.addr < 4'hF) begin
            s_next.taskFile[3'(mc.addr - HPR_MC_TF)] = mc.data;
          end
        end
      endcase
    end
    // Micro read data, registered
    case (mc.addr)
      HPR_MC_IFCTL: s_next.mcRd = s_reg.ifCtl;
      HPR_MC_LSTAT: s_next.mcRd = legacyStatus;
      HPR_MC_CONF: s_next.mcRd = s_reg.conf;
      HPR_MC_HSTAT: s_next.mcRd = hostStatus;
      HPR_MC_STROBE: s_next.mcRd = {s_reg.hostIntEnable, s_reg.hostDmaEnable, 6'h00};
      HPR_MC_CMD: s_next.mcRd = s_reg.cmd;
      HPR_MC_FD: s_next.mcRd = s_reg.fixedDisk;
      HPR_MC_ERR: s_next.mcRd = errReg;
      HPR_MC_TF: s_next.mcRd = s_reg.taskFile[0];
      4'hF: s_next.mcRd = 8'h00;
      default: s_next.mcRd = s_reg.taskFile[3'(mc.addr - HPR_MC_TF)];
    endcase
  end

  // State register; both busy flags read set out of reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
      s_reg.commandBusy <= 1'b1;
      s_reg.legacyBusy <= 1'b1;
      // Task-file interrupts start disabled
      s_reg.fixedDisk <= 8'h02;
    end else begin
      s_reg <= s_next;
    end
  end

  // Host interrupt flip-flop and float
  hpr_intr_gate u_intr (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .setPulse(intSet),
    .clearPulse(intClear),
    .enable(intEnable),
    .pending(intPending),
    .lineOut(hostIntLine),
    .lineOe(hostIntOe)
  );

  // Error register and search counting
  hpr_error_report u_err (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .cmdStart(startCmd),
    .retryDisable(s_reg.ifCtl[HPR_IF_NORETRY]),
    .idSearch(idSearch),
    .indexPulse(indexPulse),
    .scanSeekDone(scanSeekDone),
    .ev(errEv),
    .scanSeekReq(scanSeekReq),
    .errReg(errReg)
  );

  // DMA request gated by the mask in legacy mode only
  assign dmaRequestLine = dmaRequestFlag && (taskMode || s_reg.hostDmaEnable);
  // Registered outputs
  assign hostDataOut = s_reg.rdData;
  assign hostDataOe = s_reg.rdOe;
  assign resetOut = s_reg.rstLevel;
  assign localCpuInt = s_reg.local_cpu_interrupt;
  assign commandCode = s_reg.cmd;
  assign mcDataOut = s_reg.mcRd;
endmodule

/* core/hpr_intr_gate.sv */
// Host interrupt flip-flop with float control
`timescale 1ns/1ns
module hpr_intr_gate
  import hpr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic setPulse,
  input wire logic clearPulse,
  input wire logic enable,
  output logic pending,
  output logic lineOut,
  output logic lineOe
);
  typedef struct packed {
    logic pend;
  } hpr_intr_st_t;
  hpr_intr_st_t s_reg;
  hpr_intr_st_t s_next;

  // Set wins over clear so a late event is not lost
  always_comb begin
    s_next = s_reg;
    if (setPulse) begin
      s_next.pend = 1'b1;
    end else if (clearPulse) begin
      s_next.pend = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pending = s_reg.pend;
  assign lineOut = s_reg.pend;
  // Line floats while disabled
  assign lineOe = enable;
endmodule

/* core/hpr_pkg.sv */
// Shared constants and carriers for the host port register decode block
package hpr_pkg;
  // Host port offsets
  localparam logic [2:0] HPR_OFF_DATA = 3'h0;
  localparam logic [2:0] HPR_OFF_STAT = 3'h1;
  localparam logic [2:0] HPR_OFF_CONF = 3'h2;
  localparam logic [2:0] HPR_OFF_MASK = 3'h3;
  localparam logic [2:0] HPR_OFF_ERR = 3'h1;
  localparam logic [2:0] HPR_OFF_CMD = 3'h7;
  localparam logic [2:0] HPR_OFF_ALT = 3'h6;
  localparam logic [2:0] HPR_OFF_DIN = 3'h7;
  // Mask register bits
  localparam int HPR_MASK_IRQ = 1;
  localparam int HPR_MASK_DMA = 0;
  // Fixed-disk control bits
  localparam int HPR_FD_HS3 = 3;
  localparam int HPR_FD_RST = 2;
  localparam int HPR_FD_NIEN = 1;
  // Local microcontroller offsets
  localparam logic [3:0] HPR_MC_IFCTL = 4'h0;
  localparam logic [3:0] HPR_MC_LSTAT = 4'h1;
  localparam logic [3:0] HPR_MC_CONF = 4'h2;
  localparam logic [3:0] HPR_MC_HSTAT = 4'h3;
  localparam logic [3:0] HPR_MC_STROBE = 4'h4;
  localparam logic [3:0] HPR_MC_CMD = 4'h5;
  localparam logic [3:0] HPR_MC_FD = 4'h6;
  localparam logic [3:0] HPR_MC_ERR = 4'h7;
  localparam logic [3:0] HPR_MC_TF = 4'h8;
  // Interface control bits
  localparam int HPR_IF_FLAVOUR = 0;
  localparam int HPR_IF_NORST = 1;
  localparam int HPR_IF_PIO = 2;
  localparam int HPR_IF_NORETRY = 3;
  // Strobe bits
  localparam int HPR_SB_UNBUSY = 0;
  localparam int HPR_SB_IRQ = 1;
  localparam int HPR_SB_RSTOFF = 2;
  // Micro-owned bits of the status bytes
  localparam logic [7:0] HPR_LSTAT_MC = 8'hC6;
  localparam logic [7:0] HPR_HSTAT_MC = 8'h75;
  // Index pulse counts for the sector search
  localparam logic [3:0] HPR_IDX_RETRY = 4'hA;
  localparam logic [3:0] HPR_IDX_NORETRY = 4'h2;
  localparam logic [15:0] HPR_DATA_MARK = 16'hA1F8;
  // Host bus cycle
  typedef struct packed {
    logic sel;
    logic rd;
    logic wr;
    logic high;
    logic [2:0] addr;
    logic [15:0] data;
  } hpr_host_bus_t;
  // Local microcontroller write/select
  typedef struct packed {
    logic wr;
    logic [3:0] addr;
    logic [7:0] data;
  } hpr_mc_bus_t;
  // Error events from the formatter
  typedef struct packed {
    logic badBlock;
    logic eccError;
    logic homeTrack;
    logic notReady;
    logic writeFault;
    logic illegalCode;
    logic markCheck;
    logic readSector;
    logic [15:0] markBytes;
  } hpr_err_ev_t;
endpackage

/* test/hpr_host_model.sv */
// Host processor model: port decode and single I/O cycles
`timescale 1ns/1ns
module hpr_host_model
  import hpr_pkg::*;
(
  input wire logic clk_sys,
  output hpr_host_bus_t bus
);
  // Idle bus; undriven data lines show junk
  initial bus = '{sel: 1'b0, rd: 1'b0, wr: 1'b0, high: 1'b0, addr: 3'h0, data: 16'hFFFF};
  // One cycle at a system port; decode covers the primary sets only
  task automatic io(input logic w, input logic [9:0] port, input logic [15:0] d);
    logic hit;
    hit = port[9:3] == 7'h64 || port[9:3] == 7'h3E || port[9:1] == 9'h1FB;
    @(posedge clk_sys);
    #2;
    bus = '{sel: hit, rd: !w, wr: w, high: port[9], addr: port[2:0], data: w ? d : ~d};
    @(posedge clk_sys);
    #2;
    bus = '{sel: 1'b0, rd: 1'b0, wr: 1'b0, high: 1'b0, addr: 3'h0, data: ~d};
  endtask
endmodule

/* test/hpr_host_port_register_decode_asserts.sv */
// Concurrent checks on the host port register decode block
`timescale 1ns/1ns
module hpr_host_port_register_decode_asserts
  import hpr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire hpr_host_bus_t host,
  input wire hpr_mc_bus_t mc,
  input wire logic hostDataOe,
  input wire logic wideCycle,
  input wire logic hostIntLine,
  input wire logic dmaRequestLine,
  input wire logic dmaRequestFlag,
  input wire logic resetOut,
  input wire logic bufRdStrobe,
  input wire logic bufWrStrobe,
  input wire logic localCpuInt,
  input wire logic scanSeekReq
);
  // Single domain, checks off while reset is held
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Read answer is exactly one cycle behind its strobe
  AST_RD_ANSWER: assert property (host.sel && host.rd |=> hostDataOe)
    else $error("read data enable missing");
  AST_OE_CAUSE: assert property (hostDataOe |-> $past(host.sel && host.rd))
    else $error("read data enable without a read");
  AST_WIDE: assert property (wideCycle |-> host.sel && !host.high && host.addr == HPR_OFF_DATA)
    else $error("wide cycle outside data port");
  AST_DMA_LINE: assert property (dmaRequestLine |-> dmaRequestFlag)
    else $error("dma line without request");
  AST_BUF_RD: assert property (bufRdStrobe |-> host.sel && host.rd && host.addr == HPR_OFF_DATA)
    else $error("buffer read without data port read");
  AST_BUF_WR: assert property (bufWrStrobe |-> host.sel && host.wr && host.addr == HPR_OFF_DATA)
    else $error("buffer write without data port write");
  AST_RESET_OUT: assert property ($rose(resetOut) |-> $past(host.sel && host.wr))
    else $error("reset output rose without host write");
  // Micro interrupt is a single pulse caused by a host write
  AST_CPU_INT: assert property (localCpuInt |-> $past(host.sel && host.wr) ##1 !localCpuInt)
    else $error("local interrupt pulse wrong");
  AST_INT_SET: assert property ($rose(hostIntLine) |-> $past(mc.wr && mc.addr == HPR_MC_STROBE))
    else $error("host interrupt rose without micro strobe");
  AST_SEEK_PULSE: assert property (scanSeekReq |=> !scanSeekReq)
    else $error("scan request longer than a pulse");
  // Interrupt, reset and DMA lines quiet on the first edge out of reset
  AST_RST_REL: assert property ($rose(nrst) |-> !hostIntLine && !resetOut && !dmaRequestLine)
    else $error("outputs active after reset");
endmodule

/* test/tb.sv */
// Self-checking bench for the host port register decode block
`timescale 1ns/1ns
module tb;
  import hpr_pkg::*;
  logic clk_sys;
  logic nrst;
  hpr_host_bus_t host;
  hpr_mc_bus_t mc;
  hpr_err_ev_t errEv;
  logic [15:0] hostDataOut, bufRdData, bufWrData;
  logic hostDataOe, wideCycle, hostIntLine, hostIntOe, dmaRequestLine, resetOut;
  logic bufReady, dmaRequestFlag, bufRdStrobe, bufWrStrobe, localCpuInt;
  logic [7:0] mcDataOut, commandCode, cfg;
  logic indexIn, writeGateIn, idSearch, indexPulse, scanSeekDone, scanSeekReq;
  int err_count, n_tests, seed, seekSeen;
  logic [15:0] expQ[$]; // Expected read data, oldest first
  logic [15:0] maskQ[$]; // Bits that matter per read

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  hpr_host_port_register_decode hpr_host_port_register_decode_i (.clk_sys(clk_sys), .nrst(nrst), .host(host),
    .hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .wideCycle(wideCycle), .hostIntLine(hostIntLine),
    .hostIntOe(hostIntOe), .dmaRequestLine(dmaRequestLine), .resetOut(resetOut), .bufRdData(bufRdData),
    .bufReady(bufReady), .dmaRequestFlag(dmaRequestFlag), .bufRdStrobe(bufRdStrobe), .bufWrStrobe(bufWrStrobe),
    .bufWrData(bufWrData), .mc(mc), .mcDataOut(mcDataOut), .localCpuInt(localCpuInt), .commandCode(commandCode),
    .indexIn(indexIn), .writeGateIn(writeGateIn), .idSearch(idSearch), .indexPulse(indexPulse),
    .scanSeekDone(scanSeekDone), .errEv(errEv), .scanSeekReq(scanSeekReq));
  hpr_host_model hpr_host_model_i (.clk_sys(clk_sys), .bus(host));

  // Compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Micro register write, one strobe
  task automatic mcw(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #2;
    mc = '{wr: 1'b1, addr: a, data: d};
    @(posedge clk_sys);
    #2;
    mc.wr = 1'b0;
  endtask
  // Host read; expectation queued for the watcher
  task automatic hrd(input logic [9:0] port, input logic [15:0] exp, input logic [15:0] m);
    expQ.push_back(exp);
    maskQ.push_back(m);
    hpr_host_model_i.io(1'b0, port, 16'h0000);
  endtask
  task automatic hwr(input logic [9:0] port, input logic [15:0] d);
    hpr_host_model_i.io(1'b1, port, d);
  endtask
  // Index pulses, one cycle wide with a gap
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #2;
      indexPulse = 1'b1;
      @(posedge clk_sys);
      #2;
      indexPulse = 1'b0;
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Watcher: each read answer takes the oldest note
  always @(posedge clk_sys) begin
    if (scanSeekReq === 1'b1) seekSeen++;
    if (hostDataOe === 1'b1) begin
      if (expQ.size() == 0) check("unexpected read", 16'h0001, 16'h0000);
      else check("hostDataOut", hostDataOut & maskQ.pop_front(), expQ.pop_front());
    end
  end

  // Hang guard
  initial begin
    #3000000;
    err_count++;
    final_report();
  end

  initial begin
    seed = 71;
    nrst = 1'b0;
    mc = '0;
    errEv = '0;
    bufRdData = 16'h0000;
    {bufReady, dmaRequestFlag, indexIn, writeGateIn, idSearch, indexPulse, scanSeekDone} = '0;
    repeat (8) @(posedge clk_sys);
    #2;
    nrst = 1'b1;
    bufReady = 1'b1;
    // Legacy mode straight out of reset: busy set
    hrd(10'h321, 16'h0009, 16'hFFFF);
    cfg = 8'($random(seed));
    mcw(HPR_MC_LSTAT, 8'hFF);
    mcw(HPR_MC_CONF, cfg);
    @(posedge clk_sys);
    #2;
    check("mcDataOut", {8'h00, mcDataOut}, {8'h00, cfg});
    mcw(HPR_MC_STROBE, 8'h01);
    hrd(10'h321, 16'h00C7, 16'hFFFF);
    hrd(10'h322, {8'h00, cfg}, 16'hFFFF);
    bufRdData = 16'($random(seed));
    hrd(10'h320, {8'h00, bufRdData[7:0]}, 16'hFFFF);
    fork
      hwr(10'h320, 16'h12A5);
      begin
        @(posedge clk_sys);
        #5;
        check("bufWrData", bufWrStrobe ? bufWrData : 16'hFFFF, 16'h00A5);
      end
    join
    // Interrupt and DMA enables, then mask both off
    hwr(10'h323, 16'h0003);
    mcw(HPR_MC_STROBE, 8'h02);
    check("hostIntLine", 16'(hostIntLine), 16'h0001);
    dmaRequestFlag = 1'b1;
    hrd(10'h321, 16'h00F7, 16'hFFFF);
    check("dmaRequestLine", 16'(dmaRequestLine), 16'h0001);
    hwr(10'h323, 16'h0000);
    @(posedge clk_sys);
    #2;
    check("hostIntLine", 16'(hostIntLine), 16'h0000);
    check("hostIntOe", 16'(hostIntOe), 16'h0000);
    check("dmaRequestLine", 16'(dmaRequestLine), 16'h0000);
    // Board select and board reset strobes
    hwr(10'h322, 16'h0055);
    check("localCpuInt", 16'(localCpuInt), 16'h0001);
    hwr(10'h321, 16'h0000);
    check("resetOut", 16'(resetOut), 16'h0001);
    hrd(10'h321, 16'h0009, 16'h0039);
    mcw(HPR_MC_STROBE, 8'h04);
    check("resetOut", 16'(resetOut), 16'h0000);
    mcw(HPR_MC_IFCTL, 8'h02);
    hwr(10'h321, 16'h0000);
    check("localCpuInt", 16'(localCpuInt), 16'h0001);
    check("resetOut", 16'(resetOut), 16'h0000);
    // Task-file mode, programmed transfers
    mcw(HPR_MC_IFCTL, 8'h05);
    mcw(HPR_MC_STROBE, 8'h01);
    bufRdData = 16'($random(seed));
    fork
      hrd(10'h1F0, bufRdData, 16'hFFFF);
      begin
        @(posedge clk_sys);
        #5;
        check("wideCycle", 16'(wideCycle), 16'h0001);
      end
    join
    hwr(10'h1F2, 16'h0033);
    hrd(10'h1F2, 16'h0033, 16'h00FF);
    hwr(10'h1F7, 16'h0020);
    check("commandCode", 16'(commandCode), 16'h0020);
    hrd(10'h1F2, 16'h0080, 16'h0080);
    hwr(10'h1F2, 16'h0044);
    // Sector search with retries, then error events
    idSearch = 1'b1;
    pulse(9);
    check("scan requests", 16'(seekSeen), 16'h0000);
    pulse(1);
    @(posedge clk_sys);
    #2;
    check("scan requests", 16'(seekSeen), 16'h0001);
    scanSeekDone = 1'b1;
    @(posedge clk_sys);
    #2;
    scanSeekDone = 1'b0;
    pulse(10);
    idSearch = 1'b0;
    errEv = '{illegalCode: 1'b1, markCheck: 1'b1, readSector: 1'b1, markBytes: 16'hA1F9, default: '0};
    @(posedge clk_sys);
    #2;
    errEv = '0;
    mcw(HPR_MC_STROBE, 8'h01);
    hrd(10'h1F2, 16'h0033, 16'h00FF);
    hrd(10'h1F1, 16'h0015, 16'h00FF);
    hrd(10'h3F6, 16'h0000, 16'h0080);
    writeGateIn = 1'b1;
    hrd(10'h3F7, 16'h0040, 16'h00FF);
    // Retry disabled: two index pulses, no scan request
    mcw(HPR_MC_IFCTL, 8'h0D);
    hwr(10'h1F7, 16'h0020);
    idSearch = 1'b1;
    pulse(2);
    idSearch = 1'b0;
    mcw(HPR_MC_STROBE, 8'h01);
    hrd(10'h1F1, 16'h0010, 16'h00FF);
    check("scan requests", 16'(seekSeen), 16'h0001);
    repeat (3) @(posedge clk_sys);
    check("pending reads", 16'(expQ.size()), 16'h0000);
    final_report();
  end
endmodule

bind hpr_host_port_register_decode hpr_host_port_register_decode_asserts hpr_host_port_register_decode_asserts_i (
  .clk_sys(clk_sys), .nrst(nrst), .host(host), .mc(mc), .hostDataOe(hostDataOe), .wideCycle(wideCycle),
  .hostIntLine(hostIntLine), .dmaRequestLine(dmaRequestLine), .dmaRequestFlag(dmaRequestFlag),
  .resetOut(resetOut), .bufRdStrobe(bufRdStrobe), .bufWrStrobe(bufWrStrobe), .localCpuInt(localCpuInt),
  .scanSeekReq(scanSeekReq));
